/* verilog/axpr_bank.sv */
// How it works
// R1: Eleven motion registers have a queued front copy; others have none.
// R2: The start command is write-only and never read back.
// R3: Host writes to active registers take effect on the running move.
// R4: On completion the queued front values are copied into the active stage.
// R5: With both stages idle, a front write also lands in the active register.
// R6: Start while idle marks the active stage determined and starts the move.
// R7: While active is determined, front writes leave active values alone.
// R8: Start while busy marks the front stage determined; flag shows it.
// R9: Completion with a determined front stage chains straight into the next move.
// R10: Completion with an undetermined front stage copies data and halts.
// R11: Front writes are dropped while the front stage is determined.
// R12: Interrupt goes low on determined to undetermined, if enabled.
// R13: The queue cancel command makes the front stage undetermined.
// R14: Immediate and decelerating stop commands make the front stage undetermined.
// R15: Stop during automatic deceleration lets the move finish but drops the queue.
// R16: A rising low error cause bit makes the front stage undetermined.
// R17: End-of-pulse timing leaves fourteen clocks before the chained start.
// R18: All registers and front registers reset to zero.
// R19: Unused bits ignore writes and read as zero.
// R20: Sign-extension bits ignore writes and read as the top implemented bit.
// R21: The target position holds a signed 28-bit value.
// R22: Writing the active target during a move overrides that move's target.
// R23: The host waits four clocks after a read command before reading data.
// R24: Reset leaves both stages undetermined and the queue flag clear.
`timescale 1ns/100ps
`default_nettype none
`include "axpr_cfg.svh"

module axpr_bank
(
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CMD_WR_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic BUF_WR_IN,
    input wire logic [31:0] BUF_DATA_IN,
    input wire logic OP_DONE_IN,
    input wire logic [6:0] ERROR_CAUSE_IN,
    input wire logic [27:0] COMMAND_POSITION_LATCH_IN,
    input wire logic [27:0] MECHANICAL_POSITION_LATCH_IN,
    input wire logic [16:0] EXTENSION_STATUS_IN,
    input wire logic [8:0] ERROR_IRQ_STATUS_IN,
    input wire logic [13:0] EVENT_IRQ_STATUS_IN,
    input wire logic [27:0] RESIDUAL_PULSE_COUNTER_IN,
    input wire logic [19:0] EZ_COUNT_SPEED_MONITOR_IN,
    input wire logic [23:0] RAMPDOWN_CALC_VALUE_IN,
    output logic [31:0] BUF_DATA_OUT,
    output logic START_OUT,
    output logic ACT_DETERMINED_OUT,
    output logic QUEUE_DETERMINED_OUT,
    output logic INTN_OUT,
    output logic [27:0] FEED_AMOUNT_OUT,
    output logic [13:0] INITIAL_SPEED_OUT,
    output logic [13:0] OPERATION_SPEED_OUT,
    output logic [13:0] ACCEL_RATE_OUT,
    output logic [13:0] DECEL_RATE_OUT,
    output logic [11:0] SPEED_MULTIPLIER_OUT,
    output logic [23:0] RAMPDOWN_SPOT_OUT,
    output logic [29:0] OPERATION_MODE_OUT,
    output logic [26:0] LINEAR_PATH_MAJOR_FEED_OUT,
    output logic [12:0] S_CURVE_ACCEL_RANGE_OUT,
    output logic [12:0] S_CURVE_DECEL_RANGE_OUT,
    output logic [31:0] TERMINAL_IO_CONFIG_OUT,
    output logic [30:0] GENERAL_PORT_CONFIG_OUT,
    output logic [21:0] ORIGIN_COUNTER_CONFIG_OUT,
    output logic [27:0] COMMAND_POSITION_COUNTER_OUT,
    output logic [27:0] MECHANICAL_POSITION_COUNTER_OUT,
    output logic [27:0] COMPARE_VALUE_ONE_OUT,
    output logic [27:0] COMPARE_VALUE_TWO_OUT
);

    function automatic int q_width(input logic [3:0] i);
        case (i)
            4'h0: q_width = 28;
            4'h1, 4'h2, 4'h3, 4'h4: q_width = 14;
            4'h5: q_width = 12;
            4'h6: q_width = 24;
            4'h7: q_width = 30;
            4'h8: q_width = 27;
            default: q_width = 13;
        endcase
    endfunction

    function automatic int cfg_width(input logic [2:0] i);
        case (i)
            3'h0: cfg_width = 32;
            3'h1: cfg_width = 31;
            3'h2: cfg_width = 22;
            3'h7: cfg_width = 13;
            default: cfg_width = 28;
        endcase
    endfunction

    // Maps a write code of the unqueued registers to its slot, bit 3 flags a miss.
    function automatic logic [3:0] cfg_slot(input logic [7:0] c);
        case (c)
            8'h9c: cfg_slot = 4'h0;
            8'h9d: cfg_slot = 4'h1;
            8'h9e: cfg_slot = 4'h2;
            8'ha3: cfg_slot = 4'h3;
            8'ha4: cfg_slot = 4'h4;
            8'ha7: cfg_slot = 4'h5;
            8'ha8: cfg_slot = 4'h6;
            8'hac: cfg_slot = 4'h7;
            default: cfg_slot = 4'h8;
        endcase
    endfunction

    // Fills bits above the implemented width with zero or with the top bit.
    function automatic logic [31:0] fmt(input logic [31:0] v, input int w, input logic sx);
        logic [31:0] r;
        r = v;
        for (int b = 0; b < 32; b++)
            if (b >= w)
                r[b] = sx & v[w - 1];
        return r;
    endfunction

    logic [31:0] pre_reg [0:10];
    logic [31:0] act_reg [0:10];
    logic [31:0] cfg_reg [0:7];
    axpr_pkg::axpr_state_type state_reg;
    logic pre_det_reg;
    logic pre_det_d_reg;
    logic start_reg;
    logic act_det_reg;
    logic intn_reg;
    logic [4:0] gap_reg;
    logic [31:0] buf_reg;
    logic [6:0] err_prev_reg;
    logic [31:0] rd_data;
    logic rd_hit;

    logic [3:0] q_idx;
    logic q_ok;
    logic wr_pre;
    logic wr_act;
    logic start_cmd;
    logic busy;
    logic done;
    logic err_rise;
    logic pre_clear;
    logic chain_take;
    logic [3:0] cfg_wr_slot;
    logic [3:0] cfg_rd_slot;
    logic [31:0] wr_val;

    assign q_idx = CMD_CODE_IN[3:0];
    assign q_ok = (q_idx <= `AXPR_Q_LAST);
    assign wr_pre = CMD_WR_IN && (CMD_CODE_IN[7:4] == `AXPR_GRP_WR_PRE) && q_ok;
    assign wr_act = CMD_WR_IN && (CMD_CODE_IN[7:4] == `AXPR_GRP_WR_ACT) && q_ok;
    assign start_cmd = CMD_WR_IN && (CMD_CODE_IN == `AXPR_CMD_START);
    assign busy = (state_reg != axpr_pkg::AXPR_IDLE);
    assign done = OP_DONE_IN && (state_reg == axpr_pkg::AXPR_RUN);
    assign err_rise = |(ERROR_CAUSE_IN & ~err_prev_reg); // [R16]
    // A decelerating stop lets the move finish but still drops the queue. [R15]
    assign pre_clear = err_rise || (CMD_WR_IN && ((CMD_CODE_IN == `AXPR_CMD_CANCEL) ||
        (CMD_CODE_IN == `AXPR_CMD_STOP_NOW) || (CMD_CODE_IN == `AXPR_CMD_STOP_DECEL))); // [R13] [R14]
    assign chain_take = done && (pre_det_reg || start_cmd) && !pre_clear;
    assign cfg_wr_slot = CMD_WR_IN ? cfg_slot(CMD_CODE_IN) : 4'h8;
    assign cfg_rd_slot = cfg_slot(CMD_CODE_IN - `AXPR_RD_OFFSET);
    assign wr_val = fmt(buf_reg, q_width(q_idx), 1'b0); // [R19] [R20]

    // Operation sequencing across the two stages.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            state_reg <= axpr_pkg::AXPR_IDLE; // [R24]
            start_reg <= 1'b0;
            act_det_reg <= 1'b0;
            gap_reg <= 5'h00;
        end
        else
        begin
            start_reg <= 1'b0;
            case (state_reg)
                axpr_pkg::AXPR_IDLE:
                begin
                    if (start_cmd)
                    begin
                        state_reg <= axpr_pkg::AXPR_RUN; // [R6]
                        start_reg <= 1'b1;
                        act_det_reg <= 1'b1;
                    end
                end
                axpr_pkg::AXPR_RUN:
                begin
                    if (done && !chain_take)
                    begin
                        state_reg <= axpr_pkg::AXPR_IDLE; // [R10]
                        act_det_reg <= 1'b0;
                    end
                    else if (chain_take && act_reg[`AXPR_IDX_MODE][`AXPR_COMPLETION_TIMING_SELECT_BIT])
                    begin
                        state_reg <= axpr_pkg::AXPR_GAP; // [R17]
                        gap_reg <= 5'(`AXPR_CHAIN_GAP - 1);
                    end
                    else if (chain_take)
                    begin
                        start_reg <= 1'b1; // [R9]
                    end
                end
                axpr_pkg::AXPR_GAP:
                begin
                    if (pre_clear && !err_rise)
                    begin
                        state_reg <= axpr_pkg::AXPR_IDLE;
                        act_det_reg <= 1'b0;
                    end
                    else if (gap_reg == 5'h01)
                    begin
                        state_reg <= axpr_pkg::AXPR_RUN; // [R17]
                        start_reg <= 1'b1;
                    end
                    else
                    begin
                        gap_reg <= gap_reg - 5'h01;
                    end
                end
                default:
                begin
                    state_reg <= axpr_pkg::AXPR_IDLE;
                    act_det_reg <= 1'b0;
                end
            endcase
        end
    end

    // Front stage determined flag; a start in the same cycle wins over a cancel, stop or error clear, but not over a completion.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            pre_det_reg <= 1'b0; // [R24]
            pre_det_d_reg <= 1'b0;
            err_prev_reg <= 7'h00;
        end
        else
        begin
            pre_det_d_reg <= pre_det_reg;
            err_prev_reg <= ERROR_CAUSE_IN;
            if (chain_take)
                pre_det_reg <= 1'b0; // [R9]
            else if (start_cmd && busy)
                pre_det_reg <= 1'b1; // [R8]
            else if (pre_clear)
                pre_det_reg <= 1'b0; // [R13] [R14] [R16]
        end
    end

    // Both stages of the eleven queued registers.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            for (int i = 0; i < `AXPR_Q_COUNT; i++)
            begin
                pre_reg[i] <= `AXPR_RESET_VAL; // [R18]
                act_reg[i] <= `AXPR_RESET_VAL;
            end
        end
        else
        begin
            if (wr_pre && !pre_det_reg) // [R11]
                pre_reg[q_idx] <= wr_val; // [R1]
            if (done)
                for (int i = 0; i < `AXPR_Q_COUNT; i++)
                    act_reg[i] <= pre_reg[i]; // [R4] [R10]
            else if (wr_act)
                act_reg[q_idx] <= wr_val; // [R3] [R22]
            else if (wr_pre && !pre_det_reg && !busy)
                act_reg[q_idx] <= wr_val; // [R5] [R7]
        end
    end

    // Unqueued writable registers.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            for (int i = 0; i < `AXPR_CFG_COUNT; i++)
                cfg_reg[i] <= `AXPR_RESET_VAL; // [R18]
        else if (!cfg_wr_slot[3])
            cfg_reg[cfg_wr_slot[2:0]] <= fmt(buf_reg, cfg_width(cfg_wr_slot[2:0]), 1'b0); // [R19]
    end

    // Read decode; the start command has no readable copy.
    always_comb
    begin
        rd_hit = CMD_WR_IN;
        rd_data = `AXPR_RESET_VAL;
        if (CMD_CODE_IN[7:4] == `AXPR_GRP_RD_PRE && q_ok) // [R2]
            rd_data = fmt(pre_reg[q_idx], q_width(q_idx), (q_idx == `AXPR_IDX_FEED) ||
                ((q_idx == `AXPR_IDX_RAMPDOWN) && !pre_reg[`AXPR_IDX_MODE][`AXPR_MSDP_BIT]));
        else if (CMD_CODE_IN[7:4] == `AXPR_GRP_RD_ACT && q_ok)
            rd_data = fmt(act_reg[q_idx], q_width(q_idx), (q_idx == `AXPR_IDX_FEED) ||
                ((q_idx == `AXPR_IDX_RAMPDOWN) && !act_reg[`AXPR_IDX_MODE][`AXPR_MSDP_BIT])); // [R20] [R21]
        else if (!cfg_rd_slot[3])
            rd_data = fmt(cfg_reg[cfg_rd_slot[2:0]], cfg_width(cfg_rd_slot[2:0]),
                cfg_rd_slot[2:0] inside {3'h3, 3'h4, 3'h5, 3'h6});
        else
        begin
            case (CMD_CODE_IN)
                8'hed: rd_data = fmt({4'h0, COMMAND_POSITION_LATCH_IN}, 28, 1'b1);
                8'hee: rd_data = fmt({4'h0, MECHANICAL_POSITION_LATCH_IN}, 28, 1'b1);
                8'hf1: rd_data = {15'h0000, EXTENSION_STATUS_IN};
                8'hf2: rd_data = {23'h000000, ERROR_IRQ_STATUS_IN};
                8'hf3: rd_data = {18'h00000, EVENT_IRQ_STATUS_IN};
                8'hf4: rd_data = fmt({4'h0, RESIDUAL_PULSE_COUNTER_IN}, 28, 1'b1);
                8'hf5: rd_data = {12'h000, EZ_COUNT_SPEED_MONITOR_IN};
                8'hf6: rd_data = {8'h00, RAMPDOWN_CALC_VALUE_IN};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // The data buffer is shared by both directions, so a read command overwrites it.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            buf_reg <= `AXPR_RESET_VAL;
        else if (rd_hit)
            buf_reg <= rd_data; // [R23]
        else if (BUF_WR_IN)
            buf_reg <= BUF_DATA_IN;
    end

    // Interrupt latch; a new release event wins over the clearing status read.
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            intn_reg <= 1'b1;
        else if (pre_det_d_reg && !pre_det_reg && cfg_reg[7][`AXPR_QUEUE_RELEASE_IRQ_ENABLE_BIT])
            intn_reg <= 1'b0; // [R12]
        else if (CMD_WR_IN && CMD_CODE_IN == `AXPR_CMD_RD_EVENT_STATUS)
            intn_reg <= 1'b1;
    end

    assign BUF_DATA_OUT = buf_reg;
    assign START_OUT = start_reg;
    assign ACT_DETERMINED_OUT = act_det_reg;
    assign QUEUE_DETERMINED_OUT = pre_det_reg; // [R8]
    assign INTN_OUT = intn_reg;
    assign FEED_AMOUNT_OUT = act_reg[0][27:0];
    assign INITIAL_SPEED_OUT = act_reg[1][13:0];
    assign OPERATION_SPEED_OUT = act_reg[2][13:0];
    assign ACCEL_RATE_OUT = act_reg[3][13:0];
    assign DECEL_RATE_OUT = act_reg[4][13:0];
    assign SPEED_MULTIPLIER_OUT = act_reg[5][11:0];
    assign RAMPDOWN_SPOT_OUT = act_reg[6][23:0];
    assign OPERATION_MODE_OUT = act_reg[7][29:0];
    assign LINEAR_PATH_MAJOR_FEED_OUT = act_reg[8][26:0];
    assign S_CURVE_ACCEL_RANGE_OUT = act_reg[9][12:0];
    assign S_CURVE_DECEL_RANGE_OUT = act_reg[10][12:0];
    assign TERMINAL_IO_CONFIG_OUT = cfg_reg[0];
    assign GENERAL_PORT_CONFIG_OUT = cfg_reg[1][30:0];
    assign ORIGIN_COUNTER_CONFIG_OUT = cfg_reg[2][21:0];
    assign COMMAND_POSITION_COUNTER_OUT = cfg_reg[3][27:0];
    assign MECHANICAL_POSITION_COUNTER_OUT = cfg_reg[4][27:0];
    assign COMPARE_VALUE_ONE_OUT = cfg_reg[5][27:0];
    assign COMPARE_VALUE_TWO_OUT = cfg_reg[6][27:0];

    start_idle_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R6]
        start_cmd && !busy |=> START_OUT && ACT_DETERMINED_OUT)
        else $error("start while idle did not begin a move");
    queue_flag_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R8]
        start_cmd && busy && !done |=> QUEUE_DETERMINED_OUT)
        else $error("start while busy did not set the queue flag");
    front_discard_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R11]
        wr_pre && pre_det_reg |=> pre_reg[$past(q_idx)] == $past(pre_reg[q_idx]))
        else $error("front write accepted while determined");
    chain_now_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R9]
        chain_take && !act_reg[7][12] |=> START_OUT && !QUEUE_DETERMINED_OUT)
        else $error("chained start missing");
    chain_gap_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R17]
        chain_take && act_reg[7][12] && !CMD_WR_IN |=>
        !START_OUT[*8] ##1 !START_OUT[*5] ##1 START_OUT)
        else $error("chained start not fourteen clocks later");
    halt_idle_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R10]
        done && !chain_take |=> !ACT_DETERMINED_OUT && !START_OUT ##1 !START_OUT)
        else $error("move did not halt without a queued step");
    queue_cancel_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R13]
        pre_clear && !start_cmd |=> !QUEUE_DETERMINED_OUT)
        else $error("cancel, stop or error left the queue determined");
    release_irq_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R12]
        $fell(pre_det_reg) && cfg_reg[7][0] |=> !INTN_OUT)
        else $error("queue release interrupt missing");
    target_sign_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN) // [R21]
        CMD_WR_IN && CMD_CODE_IN == 8'hd0 |=> BUF_DATA_OUT[31:28] == {4{BUF_DATA_OUT[27]}})
        else $error("target position read not sign extended");

endmodule

`default_nettype wire

/* pkg/axpr_cfg.svh */
`ifndef AXPR_CFG_SVH
`define AXPR_CFG_SVH

`define AXPR_RESET_VAL 32'h0000_0000
`define AXPR_Q_COUNT 11
`define AXPR_Q_LAST 4'ha
`define AXPR_CFG_COUNT 8
`define AXPR_RO_COUNT 8

`define AXPR_GRP_WR_PRE 4'h8
`define AXPR_GRP_WR_ACT 4'h9
`define AXPR_GRP_RD_PRE 4'hc
`define AXPR_GRP_RD_ACT 4'hd

`define AXPR_CMD_START 8'h50
`define AXPR_CMD_CANCEL 8'h26
`define AXPR_CMD_STOP_NOW 8'h49
`define AXPR_CMD_STOP_DECEL 8'h4a
`define AXPR_CMD_RD_EVENT_STATUS 8'hf3
`define AXPR_RD_OFFSET 8'h40

`define AXPR_IDX_FEED 4'h0
`define AXPR_IDX_RAMPDOWN 4'h6
`define AXPR_IDX_MODE 4'h7
`define AXPR_MSDP_BIT 13
`define AXPR_COMPLETION_TIMING_SELECT_BIT 12
`define AXPR_QUEUE_RELEASE_IRQ_ENABLE_BIT 0
`define AXPR_ERR_LOW_BITS 7
`define AXPR_CHAIN_GAP 14

`endif

/* pkg/axpr_pkg.sv */
package axpr_pkg;

    typedef enum logic [1:0] {
        AXPR_IDLE = 2'b00,
        AXPR_RUN = 2'b01,
        AXPR_GAP = 2'b10
    } axpr_state_type;

endpackage

/* testbench/axpr_host.sv */
`timescale 1ns/100ps
`default_nettype none

// Host processor model: posts command bytes and moves words through the data buffer.
module axpr_host
(
    input wire logic clk_in,
    input wire logic [31:0] rd_data_in,
    output logic cmd_wr_out,
    output logic [7:0] cmd_code_out,
    output logic buf_wr_out,
    output logic [31:0] buf_data_out
);
    initial
    begin
        cmd_wr_out = 1'b0;
        cmd_code_out = 8'h00;
        buf_wr_out = 1'b0;
        buf_data_out = 32'h0000_0000;
    end

    task automatic cmd(input logic [7:0] c);
        @(posedge clk_in);
        cmd_wr_out <= 1'b1;
        cmd_code_out <= c;
        @(posedge clk_in);
        cmd_wr_out <= 1'b0;
        cmd_code_out <= ~c;
        #1;
    endtask

    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        @(posedge clk_in);
        buf_wr_out <= 1'b1;
        buf_data_out <= d;
        @(posedge clk_in);
        buf_wr_out <= 1'b0;
        // The released bus shows inverted data, so a late sample cannot match by luck.
        buf_data_out <= ~d;
        cmd_wr_out <= 1'b1;
        cmd_code_out <= c;
        @(posedge clk_in);
        cmd_wr_out <= 1'b0;
        cmd_code_out <= ~c;
        #1;
    endtask

    task automatic rd(input logic [7:0] c, output logic [31:0] d);
        cmd(c);
        repeat (4) @(posedge clk_in);
        #1;
        d = rd_data_in;
    endtask
endmodule

`default_nettype wire

/* testbench/axis_preregister_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "axpr_cfg.svh"

module axis_preregister_bank_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic op_done = 1'b0;
    logic [6:0] err_cause = 7'h00;
    logic [31:0] ro = 32'h0000_0000;
    logic cmd_wr;
    logic buf_wr;
    logic [7:0] code;
    logic [31:0] bdi;
    logic [31:0] bdo;
    logic start;
    logic act_det;
    logic q_det;
    logic intn;
    logic [27:0] feed;
    logic [13:0] op_speed;
    logic [29:0] mode;
    logic [30:0] gport;
    logic [27:0] cpos;
    int checks = 0;
    int error_cnt = 0;

    always #12.5 clk = ~clk;

    axpr_host u_host
    (
        .clk_in(clk), .rd_data_in(bdo), .cmd_wr_out(cmd_wr), .cmd_code_out(code),
        .buf_wr_out(buf_wr), .buf_data_out(bdi)
    );

    axpr_bank u_dut
    (
        .SYS_CLK_IN(clk), .RESETN_IN(resetn), .CMD_WR_IN(cmd_wr), .CMD_CODE_IN(code),
        .BUF_WR_IN(buf_wr), .BUF_DATA_IN(bdi), .OP_DONE_IN(op_done),
        .ERROR_CAUSE_IN(err_cause), .COMMAND_POSITION_LATCH_IN(ro[27:0]),
        .MECHANICAL_POSITION_LATCH_IN(~ro[27:0]), .EXTENSION_STATUS_IN(ro[16:0]),
        .ERROR_IRQ_STATUS_IN(ro[8:0]), .EVENT_IRQ_STATUS_IN(ro[13:0]),
        .RESIDUAL_PULSE_COUNTER_IN(ro[27:0]), .EZ_COUNT_SPEED_MONITOR_IN(ro[19:0]),
        .RAMPDOWN_CALC_VALUE_IN(ro[23:0]), .BUF_DATA_OUT(bdo), .START_OUT(start),
        .ACT_DETERMINED_OUT(act_det), .QUEUE_DETERMINED_OUT(q_det), .INTN_OUT(intn),
        .FEED_AMOUNT_OUT(feed), .INITIAL_SPEED_OUT(), .OPERATION_SPEED_OUT(op_speed),
        .ACCEL_RATE_OUT(), .DECEL_RATE_OUT(), .SPEED_MULTIPLIER_OUT(),
        .RAMPDOWN_SPOT_OUT(), .OPERATION_MODE_OUT(mode), .LINEAR_PATH_MAJOR_FEED_OUT(),
        .S_CURVE_ACCEL_RANGE_OUT(), .S_CURVE_DECEL_RANGE_OUT(),
        .TERMINAL_IO_CONFIG_OUT(), .GENERAL_PORT_CONFIG_OUT(gport),
        .ORIGIN_COUNTER_CONFIG_OUT(), .COMMAND_POSITION_COUNTER_OUT(cpos),
        .MECHANICAL_POSITION_COUNTER_OUT(), .COMPARE_VALUE_ONE_OUT(),
        .COMPARE_VALUE_TWO_OUT()
    );

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic done();
        @(posedge clk);
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("queue flag", q_det, 32'h0);
        chk("active flag", act_det, 32'h0);
        chk("irq line", intn, 32'h1);
        for (int i = 0; i < 11; i++)
        begin
            u_host.rd(8'hc0 + i[7:0], d);
            chk("front reset", d, 32'h0);
            u_host.rd(8'hd0 + i[7:0], d);
            chk("active reset", d, 32'h0);
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [7:0] c [4] = '{8'hed, 8'hee, 8'hf4, 8'hf5};
        logic [31:0] e [4] = '{32'hf800_0155, 32'h07ff_feaa, 32'hf800_0155, 32'h0000_0155};
        u_host.wr(8'h80, 32'h0800_0001);
        chk("feed out", feed, 32'h0800_0001);
        chk("active flag", act_det, 32'h0);
        u_host.rd(8'hd0, d);
        chk("feed sign", d, 32'hf800_0001);
        u_host.rd(8'hc0, d);
        chk("front feed", d, 32'hf800_0001);
        u_host.wr(8'h91, 32'hffff_ffff);
        u_host.rd(8'hd1, d);
        chk("unused bits", d, 32'h0000_3fff);
        u_host.wr(8'h9d, 32'hffff_ffff);
        u_host.rd(8'hdd, d);
        chk("plain reg", d, 32'h7fff_ffff);
        chk("port cfg out", gport, 32'h7fff_ffff);
        u_host.wr(8'ha3, 32'hffff_ffff);
        chk("counter out", cpos, 32'h0fff_ffff);
        u_host.rd(8'he3, d);
        chk("counter sign", d, 32'hffff_ffff);
        @(posedge clk);
        ro <= 32'h0800_0155;
        for (int i = 0; i < 4; i++)
        begin
            u_host.rd(c[i], d);
            chk("read only", d, e[i]);
        end
    endtask

    task automatic t_cancel();
        logic [7:0] k [3] = '{`AXPR_CMD_CANCEL, `AXPR_CMD_STOP_NOW, `AXPR_CMD_STOP_DECEL};
        for (int i = 0; i < 4; i++)
        begin
            u_host.cmd(`AXPR_CMD_START);
            u_host.cmd(`AXPR_CMD_START);
            chk("queue flag", q_det, 32'h1);
            if (i < 3)
                u_host.cmd(k[i]);
            else
            begin
                @(posedge clk);
                err_cause <= 7'h08;
            end
            repeat (2) @(posedge clk);
            #1;
            chk("queue dropped", q_det, 32'h0);
            @(posedge clk);
            err_cause <= 7'h00;
            done();
            chk("no chain", start, 32'h0);
            chk("halted", act_det, 32'h0);
            chk("irq masked", intn, 32'h1);
        end
    endtask

    task automatic t_chain();
        logic [31:0] d;
        u_host.wr(8'hac, 32'h0000_0001);
        u_host.wr(8'h80, 32'h0000_0010);
        u_host.cmd(`AXPR_CMD_START);
        chk("start pulse", start, 32'h1);
        chk("active flag", act_det, 32'h1);
        u_host.wr(8'h80, 32'h0000_0020);
        chk("feed held", feed, 32'h10);
        u_host.wr(8'h92, 32'h0000_0123);
        chk("speed live", op_speed, 32'h123);
        u_host.wr(8'h90, 32'h0000_0030);
        chk("target live", feed, 32'h30);
        u_host.cmd(`AXPR_CMD_START);
        chk("queue flag", q_det, 32'h1);
        chk("busy start", start, 32'h0);
        u_host.wr(8'h80, 32'h0000_0040);
        u_host.rd(8'hc0, d);
        chk("front kept", d, 32'h20);
        done();
        chk("chain start", start, 32'h1);
        chk("queue clear", q_det, 32'h0);
        chk("feed moved", feed, 32'h20);
        for (int i = 0; i < 4 && intn !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("irq line", intn, 32'h0);
        u_host.rd(8'hf3, d);
        chk("irq cleared", intn, 32'h1);
        done();
        chk("halt", act_det, 32'h0);
        chk("no start", start, 32'h0);
    endtask

    task automatic t_gap();
        logic [31:0] n;
        u_host.wr(8'h87, 32'h0000_1000);
        chk("mode out", mode, 32'h0000_1000);
        u_host.cmd(`AXPR_CMD_START);
        u_host.cmd(`AXPR_CMD_START);
        done();
        n = 32'h1;
        // Bounded so that a missing chained start cannot stall the run.
        while (start !== 1'b1 && n < 32'h28)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("chain gap", n, 32'h0000_000e);
        done();
        chk("gap halt", act_det, 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        t_reset();
        t_regs();
        t_cancel();
        t_chain();
        t_gap();
        print_verdict();
    end
endmodule

`default_nettype wire
